// ### hw/rs485de_uart.sv
// Operation
// - Modem control driver bit drives line enable
// - Write at data port queues a character
// - Line status bit 5 shows holding state
// - Line status bit 6 shows shifter state
// - Receive path needs no direction control
`timescale 1ns/100ps
`default_nettype none
module rs485de_uart
  import rs485de_pkg::*;
#(
  parameter int TICK_DIV   = RS485DE_TICK_DIV,
  parameter int FIFO_DEPTH = RS485DE_FIFO_DEPTH
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [2:0] port_addr,
  input  wire logic       port_wr,
  input  wire logic       port_rd,
  input  wire logic [7:0] port_wdata,
  output logic            port_wr_ready,
  output logic [7:0]      port_rdata,
  output logic            port_rvalid,
  output logic            serial_tx,
  input  wire logic       serial_rx,
  output logic            line_driver_enable
);

  localparam int DW = $clog2(TICK_DIV + 1);

  typedef struct packed {
    logic [DW-1:0]   div_cnt;
    logic            tick;
    logic [7:0]      mcr;
    rs485de_ser_type tx_st;
    logic [3:0]      tx_cnt;
    logic [2:0]      tx_bit;
    logic [7:0]      tx_sh;
    logic            tx_line;
    logic            rx_s1;
    logic            rx_s2;
    rs485de_ser_type rx_st;
    logic [3:0]      rx_cnt;
    logic [2:0]      rx_bit;
    logic [7:0]      rx_sh;
    logic [7:0]      rx_data;
    logic            rx_ready;
    logic            overrun;
    logic            framing;
    logic [7:0]      rdata;
    logic            rvalid;
  } rs485de_state_type;

  rs485de_state_type q;
  rs485de_state_type d;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  logic [7:0]        fifo_out_data;
  logic              fifo_push;
  logic [7:0]        lsr;
  logic              rx_done;
  logic              rd_data_port;
  logic              rd_status_port;

  // Characters written to the data port are queued; a write while full is dropped
  assign fifo_push      = port_wr && (port_addr == RS485DE_TRANSMIT_DATA_PORT);
  assign fifo_out_ready = (q.tx_st == RS485DE_SER_IDLE);

  rs485de_fifo #(
    .WIDTH (RS485DE_DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (fifo_push),
    .in_ready  (port_wr_ready),
    .in_data   (port_wdata),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // Status flags read 1 while busy so the host polls until both are 0
  always_comb begin
    lsr                          = 8'h00;
    lsr[RS485DE_LSR_READY_BIT]   = q.rx_ready;
    lsr[RS485DE_LSR_OVERRUN_BIT] = q.overrun;
    lsr[RS485DE_LSR_FRAMING_BIT] = q.framing;
    lsr[RS485DE_LSR_HOLDING_BIT] = fifo_out_valid;
    lsr[RS485DE_LSR_SHIFTER_BIT] = (q.tx_st != RS485DE_SER_IDLE);
  end

  assign rd_data_port   = port_rd && (port_addr == RS485DE_TRANSMIT_DATA_PORT);
  assign rd_status_port = port_rd && (port_addr == RS485DE_LINE_STATUS_PORT);
  assign rx_done        = q.tick && (q.rx_st == RS485DE_SER_STOP) && (q.rx_cnt == RS485DE_TICK_LAST);

  always_comb begin
    d        = q;
    d.tick   = 1'b0;
    d.rvalid = port_rd;

    // Oversample tick divider
    if (q.div_cnt == DW'(TICK_DIV - 1)) begin
      d.div_cnt = '0;
      d.tick    = 1'b1;
    end else begin
      d.div_cnt = q.div_cnt + 1'b1;
    end

    // Modem control write; the driver bit follows software only
    if (port_wr && (port_addr == RS485DE_MODEM_CONTROL_PORT)) begin
      d.mcr = port_wdata & RS485DE_MCR_MASK;
    end

    // Read data is registered; unmapped locations read zero
    case (port_addr)
      RS485DE_TRANSMIT_DATA_PORT: d.rdata = q.rx_data;
      RS485DE_MODEM_CONTROL_PORT: d.rdata = q.mcr;
      RS485DE_LINE_STATUS_PORT:   d.rdata = lsr;
      default:                    d.rdata = 8'h00;
    endcase
    if (!port_rd) begin
      d.rdata = q.rdata;
    end

    // Transmitter: 16 ticks per bit, LSB first, one stop bit
    case (q.tx_st)
      RS485DE_SER_IDLE: begin
        d.tx_line = 1'b1;
        if (fifo_out_valid) begin
          d.tx_sh   = fifo_out_data;
          d.tx_cnt  = 4'h0;
          d.tx_bit  = 3'h0;
          d.tx_line = 1'b0;
          d.tx_st   = RS485DE_SER_START;
        end
      end
      RS485DE_SER_START: begin
        if (q.tick) begin
          d.tx_cnt = q.tx_cnt + 1'b1;
          if (q.tx_cnt == RS485DE_TICK_LAST) begin
            d.tx_line = q.tx_sh[0];
            d.tx_st   = RS485DE_SER_DATA;
          end
        end
      end
      RS485DE_SER_DATA: begin
        if (q.tick) begin
          d.tx_cnt = q.tx_cnt + 1'b1;
          if (q.tx_cnt == RS485DE_TICK_LAST) begin
            d.tx_bit = q.tx_bit + 1'b1;
            d.tx_sh  = {1'b0, q.tx_sh[7:1]};
            if (q.tx_bit == RS485DE_BIT_LAST) begin
              d.tx_line = 1'b1;
              d.tx_st   = RS485DE_SER_STOP;
            end else begin
              d.tx_line = q.tx_sh[1];
            end
          end
        end
      end
      RS485DE_SER_STOP: begin
        if (q.tick) begin
          d.tx_cnt = q.tx_cnt + 1'b1;
          if (q.tx_cnt == RS485DE_TICK_LAST) begin
            d.tx_st = RS485DE_SER_IDLE;
          end
        end
      end
      default: begin
        d.tx_st   = RS485DE_SER_IDLE;
        d.tx_line = 1'b1;
      end
    endcase

    // Receive line synchroniser
    d.rx_s1 = serial_rx;
    d.rx_s2 = q.rx_s1;

    // Receiver runs whatever the driver state, as on a point-to-point line
    case (q.rx_st)
      RS485DE_SER_IDLE: begin
        if (!q.rx_s2) begin
          d.rx_cnt = 4'h0;
          d.rx_st  = RS485DE_SER_START;
        end
      end
      RS485DE_SER_START: begin
        if (q.tick) begin
          d.rx_cnt = q.rx_cnt + 1'b1;
          if (q.rx_cnt == RS485DE_TICK_MID) begin
            d.rx_cnt = 4'h0;
            d.rx_bit = 3'h0;
            d.rx_st  = q.rx_s2 ? RS485DE_SER_IDLE : RS485DE_SER_DATA; // Glitch rejected
          end
        end
      end
      RS485DE_SER_DATA: begin
        if (q.tick) begin
          d.rx_cnt = q.rx_cnt + 1'b1;
          if (q.rx_cnt == RS485DE_TICK_LAST) begin
            d.rx_sh  = {q.rx_s2, q.rx_sh[7:1]};
            d.rx_bit = q.rx_bit + 1'b1;
            if (q.rx_bit == RS485DE_BIT_LAST) begin
              d.rx_st = RS485DE_SER_STOP;
            end
          end
        end
      end
      RS485DE_SER_STOP: begin
        if (q.tick) begin
          d.rx_cnt = q.rx_cnt + 1'b1;
          if (q.rx_cnt == RS485DE_TICK_LAST) begin
            d.rx_st = RS485DE_SER_IDLE;
          end
        end
      end
      default: d.rx_st = RS485DE_SER_IDLE;
    endcase

    // Flag clears by read come first so a same-cycle arrival wins
    if (rd_data_port) begin
      d.rx_ready = 1'b0;
    end
    if (rd_status_port) begin
      d.overrun = 1'b0;
      d.framing = 1'b0;
    end
    if (rx_done) begin
      d.rx_data  = q.rx_sh;
      d.rx_ready = 1'b1;
      if (q.rx_ready && !rd_data_port) begin
        d.overrun = 1'b1;
      end
      if (!q.rx_s2) begin
        d.framing = 1'b1;
      end
    end
  end

  // Reset leaves the driver off so the node never contends on the bus
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q         <= '0;
      q.mcr     <= RS485DE_MCR_RESET;
      q.tx_st   <= RS485DE_SER_IDLE;
      q.rx_st   <= RS485DE_SER_IDLE;
      q.tx_line <= 1'b1;
      q.rx_s1   <= 1'b1;
      q.rx_s2   <= 1'b1;
      q.rx_data <= RS485DE_RX_RESET;
    end else begin
      q <= d;
    end
  end

  assign line_driver_enable = q.mcr[RS485DE_MCR_DRIVER_BIT];
  assign serial_tx          = q.tx_line;
  assign port_rdata         = q.rdata;
  assign port_rvalid        = q.rvalid;

endmodule
`default_nettype wire

// ### hw/rs485de_pkg.sv
package rs485de_pkg;

  // Register locations on the I/O port
  localparam logic [2:0] RS485DE_TRANSMIT_DATA_PORT = 3'h0;
  localparam logic [2:0] RS485DE_MODEM_CONTROL_PORT = 3'h4;
  localparam logic [2:0] RS485DE_LINE_STATUS_PORT   = 3'h5;

  // Field positions
  localparam int RS485DE_MCR_DRIVER_BIT   = 0;
  localparam int RS485DE_LSR_READY_BIT    = 0;
  localparam int RS485DE_LSR_OVERRUN_BIT  = 1;
  localparam int RS485DE_LSR_FRAMING_BIT  = 3;
  localparam int RS485DE_LSR_HOLDING_BIT  = 5;
  localparam int RS485DE_LSR_SHIFTER_BIT  = 6;

  // Reset values and writable mask
  localparam logic [7:0] RS485DE_MCR_RESET = 8'h00;
  localparam logic [7:0] RS485DE_MCR_MASK  = 8'h1F;
  localparam logic [7:0] RS485DE_RX_RESET  = 8'h00;

  // Timing
  localparam int RS485DE_SYS_CLK_HZ   = 250000000;
  localparam int RS485DE_BAUD         = 9600;
  localparam int RS485DE_OVERSAMPLE   = 16;
  localparam int RS485DE_TICK_DIV     = (RS485DE_SYS_CLK_HZ + (RS485DE_BAUD * RS485DE_OVERSAMPLE) / 2)
                                        / (RS485DE_BAUD * RS485DE_OVERSAMPLE);
  localparam logic [3:0] RS485DE_TICK_LAST = 4'hF;
  localparam logic [3:0] RS485DE_TICK_MID  = 4'h7;
  localparam logic [2:0] RS485DE_BIT_LAST  = 3'h7;
  localparam int RS485DE_FIFO_DEPTH   = 32;
  localparam int RS485DE_DATA_W       = 8;

  // Serial engine states, one-hot
  typedef enum logic [3:0] {
    RS485DE_SER_IDLE  = 4'b0001,
    RS485DE_SER_START = 4'b0010,
    RS485DE_SER_DATA  = 4'b0100,
    RS485DE_SER_STOP  = 4'b1000
  } rs485de_ser_type;

endpackage

// ### hw/rs485de_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module rs485de_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } rs485de_fifo_type;

  rs485de_fifo_type q;
  rs485de_fifo_type d;
  logic             push;
  logic             pop;

  // Handshakes straight from the fill count
  assign in_ready  = (q.count != (AW+1)'(DEPTH));
  assign out_valid = (q.count != '0);
  assign out_data  = q.mem[q.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointers wrap by explicit compare so DEPTH need not be a power of two
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr_ptr] = in_data;
      d.wr_ptr        = (q.wr_ptr == AW'(DEPTH - 1)) ? '0 : q.wr_ptr + 1'b1;
    end
    if (pop) begin
      d.rd_ptr = (q.rd_ptr == AW'(DEPTH - 1)) ? '0 : q.rd_ptr + 1'b1;
    end
    case ({push, pop})
      2'b10:   d.count = q.count + 1'b1;
      2'b01:   d.count = q.count - 1'b1;
      default: d.count = q.count;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule
`default_nettype wire

// ### tb/rs485de_uart_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module rs485de_uart_assertions #(parameter int TICK_DIV = 4) (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic [2:0] port_addr,
  input wire logic       port_wr,
  input wire logic       port_rd,
  input wire logic [7:0] port_wdata,
  input wire logic       port_wr_ready,
  input wire logic [7:0] port_rdata,
  input wire logic       port_rvalid,
  input wire logic       serial_tx,
  input wire logic       serial_rx,
  input wire logic       line_driver_enable
);
  // Ten bit times plus slack: a busy line never stays high longer
  localparam int LIM = 160 * TICK_DIV + 8;
  logic [31:0] gap_q;
  logic        pend_q;
  wire logic   wr_acc = port_wr && port_addr == 3'h0 && port_wr_ready;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence wr_mcr_s; port_wr && port_addr == 3'h4; endsequence
  sequence rd_mcr_s; port_rd && port_addr == 3'h4; endsequence
  sequence rd_stat_s; port_rd && port_addr == 3'h5; endsequence
  // Cycles since the line was low or a character was queued
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gap_q  <= '0;
      pend_q <= 1'b0;
    end else begin
      gap_q  <= (wr_acc || !serial_tx) ? '0 : gap_q + 32'h1;
      pend_q <= wr_acc || (pend_q && serial_tx);
    end
  end
  drv_follow_a: assert property (wr_mcr_s |=> line_driver_enable == $past(port_wdata[0]))
    else $error("driver enable differs from bit 0");
  drv_hold_a: assert property (!(port_wr && port_addr == 3'h4) |=> $stable(line_driver_enable))
    else $error("driver enable moved by itself");
  drv_reset_a: assert property ($fell(rst) |-> !line_driver_enable)
    else $error("driver enable on after reset");
  mcr_read_a: assert property (rd_mcr_s |=> port_rdata[0] == line_driver_enable && port_rdata[7:5] == 3'h0)
    else $error("modem control readback wrong");
  tx_start_a: assert property (pend_q |-> gap_q <= LIM)
    else $error("queued character never started");
  hold_busy_a: assert property (wr_acc ##[1:4] rd_stat_s |=> port_rdata[6:5] != 2'b00)
    else $error("status empty right after a write");
  shift_busy_a: assert property (rd_stat_s ##0 !serial_tx |=> port_rdata[6])
    else $error("shifter idle while line low");
  tx_idle_a: assert property (rd_stat_s ##0 gap_q > LIM |=> port_rdata[6:5] == 2'b00)
    else $error("status busy on an idle line");
  rd_pulse_a: assert property (port_rvalid == $past(port_rd))
    else $error("read answer not one cycle later");
endmodule
bind rs485de_uart rs485de_uart_assertions #(.TICK_DIV(TICK_DIV)) u_chk (.*);
`default_nettype wire

// ### tb/rs485de_node.sv
`timescale 1ns/100ps
`default_nettype none
module rs485de_node #(parameter int BT = 64) (
  input  wire logic sys_clk,
  input  wire logic serial_tx,
  input  wire logic line_driver_enable,
  output logic      serial_rx
);
  logic [7:0] heard[$];
  // Fail-safe bias holds an undriven pair at mark
  initial serial_rx = 1'b1;
  // A disabled driver never reaches the pair, so it is not heard
  always begin : listen
    logic [7:0] b;
    @(negedge serial_tx iff line_driver_enable);
    repeat (BT / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BT) @(posedge sys_clk);
      b[i] = serial_tx;
    end
    heard.push_back(b);
    repeat (BT) @(posedge sys_clk);
  end
  // Remote frame, LSB first, sent whatever the local driver does
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk);
      serial_rx <= f[i];
      repeat (BT - 1) @(posedge sys_clk);
    end
  endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
  import rs485de_pkg::*;
;
  localparam int TD = 4;
  logic        sys_clk;
  logic        rst;
  logic [2:0]  port_addr;
  logic        port_wr;
  logic        port_rd;
  logic [7:0]  port_wdata;
  logic        port_wr_ready;
  logic [7:0]  port_rdata;
  logic        port_rvalid;
  logic        serial_tx;
  logic        serial_rx;
  logic        line_driver_enable;
  int          mismatches;
  int          check_count;
  int          acc;
  int          blk[2] = '{1, 34};
  logic [19:0] seed;
  logic [7:0]  rd_v;
  logic        rdy_v;
  logic [7:0]  sent[$];
  rs485de_uart #(.TICK_DIV(TD), .FIFO_DEPTH(RS485DE_FIFO_DEPTH)) u_dut (.*);
  rs485de_node #(.BT(16 * TD)) u_node (.*);
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  function automatic logic [19:0] lfsr(input logic [19:0] s);
    return {s[18:0], s[19] ^ s[16]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Write strobe; ready is caught as the design will sample it at the next edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    port_addr  <= a;
    port_wdata <= d;
    port_wr    <= 1'b1;
    #1;
    rdy_v = port_wr_ready;
    @(posedge sys_clk);
    port_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge sys_clk);
    port_addr <= a;
    port_rd   <= 1'b1;
    @(posedge sys_clk);
    port_rd <= 1'b0;
    #1;
    chk(port_rvalid, 1'b1); // Read answered
    rd_v = port_rdata;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog sized well past the longest block drain
  initial begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    give_verdict;
  end
  initial begin
    int n;
    {rst, port_wr, port_rd, port_addr, port_wdata} = {3'h4, 11'h000};
    {mismatches, check_count, acc} = '0;
    seed = 20'h16D4F;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk(line_driver_enable, 1'b0); // Off
    rd(3'h5);
    chk(rd_v & 8'h60, 8'h00); // Empty
    rd(3'h7);
    chk(rd_v, 8'h00); // Unmapped reads zero
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      wr(3'h4, seed[7:0]);
      rd(3'h4);
      chk(rd_v, seed[7:0] & RS485DE_MCR_MASK); // Readback
      chk(line_driver_enable, seed[0]); // Follows bit 0
    end
    wr(3'h4, 8'h00);
    #1 chk(line_driver_enable, 1'b0); // Init off
    $display("control test done");
    // One character, then a block that overfills the queue
    foreach (blk[k]) begin
      wr(3'h4, 8'h01); // Enable first
      acc = 0;
      for (int i = 0; i < blk[k]; i++) begin
        seed = lfsr(seed);
        wr(3'h0, seed[7:0]);
        // Model: the engine takes the first character, the queue holds the next ones
        chk(8'(rdy_v), 8'(i <= RS485DE_FIFO_DEPTH)); // Room expected
        if (i <= RS485DE_FIFO_DEPTH)
          sent.push_back(seed[7:0]);
        acc += int'(rdy_v);
      end
      chk(8'(acc), 8'(blk[k] > RS485DE_FIFO_DEPTH ? RS485DE_FIFO_DEPTH + 1 : blk[k])); // Overflow drop
      n = 0;
      do begin
        rd(3'h5);
        n++;
      end while (rd_v[6:5] !== 2'b00 && n < 12000);
      chk(8'(n < 12000), 8'h01); // Empty reached
      chk(8'(u_node.heard.size()), 8'(sent.size())); // All sent
      while (sent.size() > 0 && u_node.heard.size() > 0)
        chk(u_node.heard.pop_front(), sent.pop_front()); // Order and value
      sent.delete();
      wr(3'h4, 8'h00);
      #1 chk(line_driver_enable, 1'b0); // Released
      $display("transmit test %0d done", k);
    end
    for (int e = 0; e < 2; e++) begin
      seed = lfsr(seed);
      wr(3'h4, 8'(e));
      u_node.send(seed[7:0]);
      repeat (16 * TD) @(posedge sys_clk);
      rd(3'h5);
      chk(rd_v[0], 1'b1); // Ready either way
      rd(3'h0);
      chk(rd_v, seed[7:0]);
    end
    // Two characters with no read between: the second overruns the first
    u_node.send(8'h5A);
    u_node.send(8'hA5);
    repeat (16 * TD) @(posedge sys_clk);
    rd(3'h5);
    chk(rd_v & 8'h0B, 8'h03); // Ready and overrun
    rd(3'h5);
    chk(rd_v & 8'h0A, 8'h00); // Status read cleared errors
    rd(3'h0);
    chk(rd_v, 8'hA5); // Newest character kept
    $display("receive test done");
    give_verdict;
  end
endmodule
`default_nettype wire
